// ==== rtl/pmic_seq_cfg.svh ====
`ifndef PMIC_SEQ_CFG_SVH
`define PMIC_SEQ_CFG_SVH

// register map, seven-bit addresses on the serial port
`define ADDR_CHIP_ID        7'h48
`define ADDR_RAIL_TRIM      7'h49
`define ADDR_GPIO_CTRL      7'h4a
`define ADDR_GPIO_STAT      7'h4b
`define ADDR_PWS_CTRL       7'h4c
`define ADDR_PWS_STAT       7'h4d
`define ADDR_USB_FLAG_CTRL  7'h4e
`define ADDR_USB_FLAG_STAT  7'h4f

// reset values and field positions
`define RST_BYTE            8'h00
`define CHIP_ID_DEFAULT     8'h5c
`define FLAG_CLEAR_BIT      0
`define SLEEP_REQ_BIT       1
`define CMD_WRITE_BIT       7
`define GPIO_OE_LSB         0
`define GPIO_DO_LSB         4

// serial frame: command byte then data byte
`define SPI_BYTE_BITS       5'd8
`define SPI_FRAME_BITS      5'd16

// timing, figures in their own units
`define CLK_HZ              64'd50000000
`define RESET_HOLD_MS       64'd150
`define STANDALONE_LIMIT_S  64'd3600
`define SLEEP_LIMIT_S       64'd86400
`define MS_PER_S            64'd1000
`define TIMER_W             48

`endif

// ==== rtl/pmic_seq_pkg.sv ====
package pmic_seq_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF       = 3'b000,
      ST_PRECHARGE = 3'b001,
      ST_RST_HOLD  = 3'b010,
      ST_ACTIVE    = 3'b011,
      ST_SLEEP     = 3'b100,
      ST_SHUTDOWN  = 3'b101
   } seq_state_t;

   // whole state of the sequencer
   typedef struct packed {
      seq_state_t  st;
      logic [47:0] timer;
      logic        usbFlag;
      logic [1:0]  pwrEnSync;
      logic [1:0]  shdnSync;
      logic [2:0]  sclkSync;
      logic [1:0]  csSync;
      logic [1:0]  mosiSync;
      logic [4:0]  bitCnt;
      logic [7:0]  shiftIn;
      logic [7:0]  cmd;
      logic [7:0]  misoShift;
      logic        miso;
      logic [7:0]  trim;
      logic [7:0]  gpioCtrl;
      logic [7:0]  pwsCtrl;
      logic        intRstN;
      logic        compRstN;
      logic        hostRstN;
      logic        supplies;
      logic        chgEn;
      logic        chgSleep;
   } seq_regs_t;

endpackage

// ==== rtl/pmic_startup_reset_sequencer.sv ====
`timescale 1ns/100ps
`include "pmic_seq_cfg.svh"

module pmic_startup_reset_sequencer
   import pmic_seq_pkg::*;
#(
   parameter logic [47:0] RESET_HOLD_CYCLES =
      48'(`RESET_HOLD_MS * `CLK_HZ / `MS_PER_S),
   parameter logic [47:0] STANDALONE_CYCLES =
      48'(`STANDALONE_LIMIT_S * `CLK_HZ),
   parameter logic [47:0] SLEEP_CYCLES =
      48'(`SLEEP_LIMIT_S * `CLK_HZ)
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // supply power-on detectors, high while supply not good
   input  wire logic       regulatorInputPor,
   input  wire logic       coreSupplyPor,
   // control pins
   input  wire logic       powerEn,
   input  wire logic       shutdown_in_n,
   input  wire logic       monitorResetReq_n,
   // charger and thermistor status
   input  wire logic       usbPresent,
   input  wire logic       batt1NeedsPrecharge,
   input  wire logic       batt1Charged,
   input  wire logic       thermInWindow,
   // status from the analog side
   input  wire logic [3:0] gpioIn,
   input  wire logic [3:0] pwsStatusIn,
   // serial register port
   input  wire logic       spiSclk,
   input  wire logic       spiCs_n,
   input  wire logic       spiMosi,
   output logic            spiMiso,
   // resets
   output logic            host_reset_out_n,
   output logic            companionReset_n,
   // power and charge controls
   output logic            suppliesOn,
   output logic            usbChargeEn,
   output logic            usbChargeSleepCurrent,
   // configuration outputs
   output logic [7:0]      railTrim,
   output logic [3:0]      gpioOut,
   output logic [3:0]      gpioOe,
   output logic [7:0]      powerSwitchCtrl
);

   // detectors and pin share one synchroniser, so release is glitch free
   // async assert, sync release of the combined reset
   logic       coreRstAsync_n;
   logic [1:0] rstSync_q;
   logic       coreRst_n;

   assign coreRstAsync_n = rst_n & ~(regulatorInputPor | coreSupplyPor);

   always_ff @(posedge clk or negedge coreRstAsync_n) begin
      if (!coreRstAsync_n) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign coreRst_n = rstSync_q[1];

   seq_regs_t r_q;
   seq_regs_t r_d;

   // reset image of the whole state
   localparam seq_regs_t REGS_RESET = '{
      st:        ST_OFF,
      timer:     '0,
      usbFlag:   1'b0,
      pwrEnSync: 2'b00,
      shdnSync:  2'b11,
      sclkSync:  3'b000,
      csSync:    2'b11,
      mosiSync:  2'b00,
      bitCnt:    5'd0,
      shiftIn:   `RST_BYTE,
      cmd:       `RST_BYTE,
      misoShift: `RST_BYTE,
      miso:      1'b0,
      trim:      `RST_BYTE,
      gpioCtrl:  `RST_BYTE,
      pwsCtrl:   `RST_BYTE,
      intRstN:   1'b0,
      compRstN:  1'b0,
      hostRstN:  1'b0,
      supplies:  1'b0,
      chgEn:     1'b0,
      chgSleep:  1'b0
   };

   // status nibbles come live from the pins, never from a stale copy
   // read mux for the register port
   function automatic logic [7:0] readReg(input logic [6:0] a,
                                          input seq_regs_t s);
      logic [7:0] v;
      v = `RST_BYTE;
      unique case (a)
         `ADDR_CHIP_ID:       v = `CHIP_ID_DEFAULT; // arbitrary value
         `ADDR_RAIL_TRIM:     v = s.trim;
         `ADDR_GPIO_CTRL:     v = s.gpioCtrl;
         `ADDR_GPIO_STAT:     v = {4'h0, gpioIn};
         `ADDR_PWS_CTRL:      v = s.pwsCtrl;
         `ADDR_PWS_STAT:      v = {4'h0, pwsStatusIn};
         `ADDR_USB_FLAG_STAT: v = {7'h00, s.usbFlag};
         default:             v = `RST_BYTE; // write-only and unmapped
      endcase
      return v;
   endfunction

   always_comb begin
      logic       sclkRise;
      logic       sclkFall;
      logic       wrStrobe;
      logic       flagClear;
      logic       sleepReq;
      logic       flagSet;
      logic       pwrEnS;
      logic       shdnS;
      logic [7:0] byteIn;
      sclkRise  = 1'b0;
      sclkFall  = 1'b0;
      wrStrobe  = 1'b0;
      flagClear = 1'b0;
      sleepReq  = 1'b0;
      flagSet   = 1'b0;
      pwrEnS    = r_q.pwrEnSync[1];
      shdnS     = r_q.shdnSync[1];
      byteIn    = {r_q.shiftIn[6:0], r_q.mosiSync[1]};
      r_d       = r_q;

      // pin synchronisers, first stage feeds only the second
      r_d.pwrEnSync = {r_q.pwrEnSync[0], powerEn};
      r_d.shdnSync  = {r_q.shdnSync[0], shutdown_in_n};
      r_d.sclkSync  = {r_q.sclkSync[1:0], spiSclk};
      r_d.csSync    = {r_q.csSync[0], spiCs_n};
      r_d.mosiSync  = {r_q.mosiSync[0], spiMosi};
      // edges compare settled stages only, a slow pin edge counts once
      sclkRise = r_q.sclkSync[1] & ~r_q.sclkSync[2];
      sclkFall = ~r_q.sclkSync[1] & r_q.sclkSync[2];

      // serial slave, mode 0: sample on rise, shift out on fall
      if (r_q.csSync[1]) begin
         r_d.bitCnt = 5'd0;
      end else if (sclkRise && r_q.bitCnt < `SPI_FRAME_BITS) begin
         r_d.shiftIn = byteIn;
         r_d.bitCnt  = r_q.bitCnt + 5'd1;
         if (r_q.bitCnt == `SPI_BYTE_BITS - 5'd1) begin
            r_d.cmd       = byteIn;
            r_d.misoShift = readReg(byteIn[6:0], r_q);
         end
         if (r_q.bitCnt == `SPI_FRAME_BITS - 5'd1) begin
            wrStrobe = r_q.cmd[`CMD_WRITE_BIT];
         end
      end else if (sclkFall && r_q.bitCnt >= `SPI_BYTE_BITS) begin
         r_d.miso      = r_q.misoShift[7];
         r_d.misoShift = {r_q.misoShift[6:0], 1'b0};
      end

      // register writes
      if (wrStrobe) begin
         unique case (r_q.cmd[6:0])
            `ADDR_RAIL_TRIM: r_d.trim     = byteIn;
            `ADDR_GPIO_CTRL: r_d.gpioCtrl = byteIn;
            `ADDR_PWS_CTRL:  r_d.pwsCtrl  = byteIn;
            `ADDR_USB_FLAG_CTRL: begin
               flagClear = byteIn[`FLAG_CLEAR_BIT];
               sleepReq  = byteIn[`SLEEP_REQ_BIT];
            end
            default: ;
         endcase
      end

      // configuration cleared while the processor is in reset
      // the host cannot find stale trim or gpio settings after its reset
      if (!r_q.hostRstN) begin
         r_d.trim     = `RST_BYTE;
         r_d.gpioCtrl = `RST_BYTE;
         r_d.pwsCtrl  = `RST_BYTE;
      end

      // sequencer; timer restarts on every state change
      // timer is wide enough for the day-long sleep limit at full clock
      r_d.timer = r_q.timer + 48'd1;
      unique case (r_q.st)
         ST_OFF: begin
            // flag keeps a flat battery from re-entering precharge
            if (usbPresent && batt1NeedsPrecharge && !r_q.usbFlag &&
                thermInWindow) begin
               r_d.st  = ST_PRECHARGE;
               flagSet = 1'b1;
            end else if (pwrEnS) begin
               r_d.st = ST_RST_HOLD;
            end
         end
         ST_PRECHARGE: begin
            if (!batt1NeedsPrecharge || !usbPresent || !thermInWindow ||
                r_q.timer >= STANDALONE_CYCLES - 48'd1) begin
               r_d.st = ST_RST_HOLD;
            end
         end
         ST_RST_HOLD: begin
            if (!pwrEnS && !r_q.usbFlag) begin
               r_d.st = ST_OFF;
            end else if (r_q.timer >= RESET_HOLD_CYCLES - 48'd1) begin
               r_d.st = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!pwrEnS) begin
               r_d.st = ST_OFF;
            end else if (sleepReq) begin
               r_d.st = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (batt1Charged || !usbPresent || !thermInWindow ||
                r_q.timer >= SLEEP_CYCLES - 48'd1) begin
               r_d.st = ST_OFF;
            end
         end
         ST_SHUTDOWN: begin
            r_d.st = ST_OFF;
         end
         default: begin
            r_d.st = ST_OFF;
         end
      endcase
      // shutdown pin overrides every state
      // a held pin parks the machine there until it is released
      if (!shdnS) begin
         r_d.st = ST_SHUTDOWN;
      end
      if (r_d.st != r_q.st) begin
         r_d.timer = '0;
      end

      // set wins over a clear in the same cycle
      if (flagSet) begin
         r_d.usbFlag = 1'b1;
      end else if (flagClear) begin
         r_d.usbFlag = 1'b0;
      end

      // outputs decoded from the next state
      // decoding the next state keeps outputs one flop from the change
      r_d.intRstN  = (r_d.st == ST_ACTIVE);
      r_d.compRstN = (r_d.st == ST_ACTIVE);
      r_d.hostRstN = r_d.intRstN & monitorResetReq_n;
      r_d.supplies = (r_d.st == ST_RST_HOLD) || (r_d.st == ST_ACTIVE);
      r_d.chgEn    = (r_d.st == ST_PRECHARGE) || (r_d.st == ST_SLEEP);
      r_d.chgSleep = (r_d.st == ST_SLEEP);
   end

   // the single state register; power-on reset loads REGS_RESET into all of it
   // the flag is kept through processor reset; power-on or the clear bit at 0x4e clears it
   always_ff @(posedge clk or negedge coreRst_n) begin
      if (!coreRst_n) begin
         r_q <= REGS_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // every output straight from the state register
   assign spiMiso               = r_q.miso;
   assign host_reset_out_n      = r_q.hostRstN;
   assign companionReset_n      = r_q.compRstN;
   assign suppliesOn            = r_q.supplies;
   assign usbChargeEn           = r_q.chgEn;
   assign usbChargeSleepCurrent = r_q.chgSleep;
   assign railTrim              = r_q.trim;
   assign gpioOut               = r_q.gpioCtrl[`GPIO_DO_LSB +: 4];
   assign gpioOe                = r_q.gpioCtrl[`GPIO_OE_LSB +: 4];
   assign powerSwitchCtrl       = r_q.pwsCtrl;

endmodule

// ==== tb/pmic_host_model.sv ====
`timescale 1ns/100ps
module pmic_host_model (
   // clock
   input wire logic clk,
   // serial port, host drives
   output logic     spiSclk,
   output logic     spiCs_n,
   output logic     spiMosi,
   input wire logic spiMiso,
   // power enable pin
   output logic     powerEn
);
   // idle pins, device starts switched off
   initial begin
      spiSclk = 1'b0;
      spiCs_n = 1'b1;
      spiMosi = 1'b0;
      powerEn = 1'b0;
   end

   // one frame: command byte then data byte, msb first, 6 clk low and 5 clk high per bit
   task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
                        output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      rd = 8'h00;
      @(posedge clk) spiCs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk) spiMosi <= sh[i];
         repeat (5) @(posedge clk);
         spiSclk <= 1'b1;
         if (i < 8) rd = {rd[6:0], spiMiso};
         repeat (5) @(posedge clk);
         spiSclk <= 1'b0;
      end
      repeat (5) @(posedge clk);
      spiCs_n <= 1'b1;
      spiMosi <= ~spiMosi; // released line shows no stale bit
      repeat (6) @(posedge clk);
   endtask

   // host drops or raises power enable
   task automatic set_power(input logic on);
      @(posedge clk) powerEn <= on;
   endtask

   // write one to the flag clear bit at 0x4e
   task automatic clear_flag();
      logic [7:0] r;
      frame(8'hce, 8'h01, r);
   endtask
endmodule

// ==== tb/pmic_seq_checker.sv ====
`timescale 1ns/100ps
module pmic_seq_checker #(
   parameter longint HOLD  = 20,
   parameter longint STAND = 50,
   parameter longint SLEEP = 80
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // inputs watched
   input wire logic regulatorInputPor,
   input wire logic coreSupplyPor,
   input wire logic monitorResetReq_n,
   input wire logic shutdown_in_n,
   input wire logic thermInWindow,
   // outputs watched
   input wire logic host_reset_out_n,
   input wire logic companionReset_n,
   input wire logic suppliesOn,
   input wire logic usbChargeEn,
   input wire logic usbChargeSleepCurrent
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   int holdCnt_q;
   int chgCnt_q;

   // run lengths of reset hold and of charging, too long for repetition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         holdCnt_q <= 0;
         chgCnt_q <= 0;
      end else begin
         holdCnt_q <= (suppliesOn && !companionReset_n) ? holdCnt_q + 1 : 0;
         chgCnt_q <= usbChargeEn ? chgCnt_q + 1 : 0;
      end
   end

   a_por_core_reset: assert property (
      (regulatorInputPor || coreSupplyPor) |->
      !host_reset_out_n && !companionReset_n && !suppliesOn)
      else $error("outputs live during power-on reset");
   a_monitor_and: assert property (
      !monitorResetReq_n |=> !host_reset_out_n)
      else $error("monitor reset not on host reset");
   a_host_needs_internal: assert property (
      host_reset_out_n |-> companionReset_n)
      else $error("host reset high while internal reset low");
   a_sleep_core_off: assert property (
      usbChargeSleepCurrent |->
      usbChargeEn && !suppliesOn && !companionReset_n)
      else $error("sleep charge with core running");
   a_shutdown_stops: assert property (
      !shutdown_in_n [*3] |-> ##[0:3] (!suppliesOn && !companionReset_n))
      else $error("shutdown did not stop supplies");
   a_therm_stops_charge: assert property (
      !thermInWindow [*2] |-> ##[0:3] !usbChargeEn)
      else $error("charging outside temperature window");
   a_hold_length: assert property (
      $rose(companionReset_n) |->
      holdCnt_q >= HOLD - 1 && holdCnt_q <= HOLD + 2)
      else $error("reset hold length wrong");
   a_charge_timer: assert property (
      usbChargeEn |->
      chgCnt_q <= (usbChargeSleepCurrent ? SLEEP : STAND) + 3)
      else $error("charge safety timer overrun");

   // main scenarios reached
   c_sleep: cover property ($rose(usbChargeSleepCurrent));
   c_active: cover property ($rose(companionReset_n));
   c_monitor: cover property (!monitorResetReq_n && companionReset_n);
endmodule

bind pmic_startup_reset_sequencer pmic_seq_checker #(
   .HOLD(RESET_HOLD_CYCLES), .STAND(STANDALONE_CYCLES),
   .SLEEP(SLEEP_CYCLES)
) u_chk (
   .clk, .rst_n, .regulatorInputPor, .coreSupplyPor,
   .monitorResetReq_n, .shutdown_in_n, .thermInWindow,
   .host_reset_out_n, .companionReset_n, .suppliesOn,
   .usbChargeEn, .usbChargeSleepCurrent
);

// ==== tb/pmic_startup_reset_sequencer_bench.sv ====
`timescale 1ns/100ps
`include "pmic_seq_cfg.svh"
module pmic_startup_reset_sequencer_bench;
   localparam int HOLD = 20;
   localparam int STAND = 50;
   localparam int SLEEP = 80;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic porA = 1'b0, porB = 1'b0, shutdown_in_n = 1'b1, monReq_n = 1'b1;
   logic usb = 1'b0, needs = 1'b0, charged = 1'b0, therm = 1'b0;
   logic [3:0] gpioIn = 4'h0, pwsIn = 4'h0, gpioOut, gpioOe;
   logic powerEn, spiSclk, spiCs_n, spiMosi, spiMiso;
   logic hostRst_n, compRst_n, supOn, chgEn, chgSleep;
   logic [7:0] trim, pwsCtrl, rd, d;
   logic [6:0] a;
   logic [7:0] sh [8] = '{default: 8'h00};
   logic [6:0] addrs [8] = '{7'h48, 7'h49, 7'h4a, 7'h4b, 7'h4c, 7'h4d,
                             7'h4f, 7'h50};
   int seed = 32'hc711;
   int num_errors = 0;
   int n_tests = 0;
   // packed view: sleep, charge, supplies, companion, host
   wire [7:0] st = {3'b0, chgSleep, chgEn, supOn, compRst_n, hostRst_n};

   always #10 clk = ~clk;

   pmic_startup_reset_sequencer #(
      .RESET_HOLD_CYCLES(48'(HOLD)), .STANDALONE_CYCLES(48'(STAND)),
      .SLEEP_CYCLES(48'(SLEEP))
   ) u_dut (
      .clk, .rst_n, .regulatorInputPor(porA), .coreSupplyPor(porB),
      .powerEn, .shutdown_in_n, .monitorResetReq_n(monReq_n),
      .usbPresent(usb), .batt1NeedsPrecharge(needs),
      .batt1Charged(charged), .thermInWindow(therm), .gpioIn,
      .pwsStatusIn(pwsIn), .spiSclk, .spiCs_n, .spiMosi, .spiMiso,
      .host_reset_out_n(hostRst_n), .companionReset_n(compRst_n),
      .suppliesOn(supOn), .usbChargeEn(chgEn),
      .usbChargeSleepCurrent(chgSleep), .railTrim(trim), .gpioOut,
      .gpioOe, .powerSwitchCtrl(pwsCtrl)
   );

   pmic_host_model u_host (
      .clk, .spiSclk, .spiCs_n, .spiMosi, .spiMiso, .powerEn
   );

   // readback expected from the register table and bench shadow
   function automatic logic [7:0] expRead(input logic [6:0] ad);
      case (ad)
         7'h48: expRead = `CHIP_ID_DEFAULT;
         7'h49, 7'h4a, 7'h4c: expRead = sh[ad[2:0]];
         7'h4b: expRead = {4'h0, gpioIn};
         7'h4d: expRead = {4'h0, pwsIn};
         7'h4f: expRead = 8'h01; // flag is set while this runs
         default: expRead = 8'h00;
      endcase
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic rdReg(input logic [6:0] ad, input logic [7:0] exp);
      u_host.frame({1'b0, ad}, 8'h00, rd);
      check(rd, exp);
   endtask

   task automatic wrReg(input logic [6:0] ad, input logic [7:0] dat);
      u_host.frame({1'b1, ad}, dat, rd);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard, about four times the expected run
   initial begin
      wt(30000);
      num_errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      stop_test();
   end

   // main sequence
   initial begin
      wt(20);
      rst_n <= 1'b1;
      wt(5);
      check(st, 8'h00);
      rdReg(7'h4f, 8'h00);
      $display("reset test done");
      usb <= 1'b1;
      needs <= 1'b1;
      wt(10);
      check(st, 8'h00);
      therm <= 1'b1;
      wt(6);
      check(st, 8'h08);
      u_host.set_power(1'b1);
      wt(STAND);
      check(st, 8'h04);
      wt(HOLD);
      check(st, 8'h07);
      rdReg(7'h4f, 8'h01);
      // flag set, usb and flat battery present: off must not precharge
      u_host.set_power(1'b0);
      wt(6);
      check(st, 8'h00);
      u_host.set_power(1'b1);
      wt(HOLD + 8);
      check(st, 8'h07);
      $display("precharge test done");
      // fixed walk over the map first, random addresses after
      for (int i = 0; i < 14; i++) begin
         a = (i < 8) ? addrs[i] : addrs[$random(seed) & 7];
         d = 8'($random(seed));
         gpioIn <= 4'($random(seed));
         pwsIn <= 4'($random(seed));
         wrReg(a, d);
         if (a inside {7'h49, 7'h4a, 7'h4c}) sh[a[2:0]] = d;
         rdReg(a, expRead(a));
      end
      check(trim, sh[1]);
      check({gpioOut, gpioOe}, sh[2]);
      check(pwsCtrl, sh[4]);
      $display("register test done");
      monReq_n <= 1'b0;
      wt(3 + ($random(seed) & 3));
      check(st, 8'h06);
      monReq_n <= 1'b1;
      wt(3);
      check(trim | pwsCtrl | {gpioOut, gpioOe}, 8'h00);
      wrReg(7'h4e, 8'h00);
      check(st, 8'h07);
      rdReg(7'h4f, 8'h01);
      u_host.clear_flag();
      rdReg(7'h4f, 8'h00);
      $display("monitor and flag test done");
      needs <= 1'b0;
      wrReg(7'h4e, 8'h02);
      check(st, 8'h18);
      wt(SLEEP);
      check(st, 8'h04);
      wt(HOLD);
      wrReg(7'h4e, 8'h02);
      therm <= 1'b0;
      wt(4);
      check(st & 8'h18, 8'h00);
      therm <= 1'b1;
      wt(HOLD + 5);
      // sleep charge ends once the battery reports charged
      wrReg(7'h4e, 8'h02);
      charged <= 1'b1;
      wt(4);
      check(st & 8'h18, 8'h00);
      charged <= 1'b0;
      wt(HOLD + 5);
      u_host.set_power(1'b0);
      wt(6);
      check(st, 8'h00);
      $display("sleep and power test done");
      u_host.set_power(1'b1);
      wt(HOLD + 8);
      check(st, 8'h07);
      shutdown_in_n <= 1'b0;
      wt(6);
      check(st, 8'h00);
      shutdown_in_n <= 1'b1;
      wt(HOLD + 8);
      check(st, 8'h07);
      porB <= 1'b1;
      wt(2);
      check(st, 8'h00);
      porB <= 1'b0;
      porA <= 1'b1;
      wt(2);
      check(st, 8'h00);
      porA <= 1'b0;
      wt(HOLD + 10);
      check(st, 8'h07);
      $display("shutdown and power-on test done");
      stop_test();
   end
endmodule
